/* File: logic/charger_regs.svh */
// register offsets, field positions, reset values and timing counts for the charger control
`ifndef CHARGER_REGS_SVH
`define CHARGER_REGS_SVH
`define CHG_REG_CTRL1 8'h00
`define CHG_REG_CTRL2 8'h04
`define CHG_REG_USB 8'h08
`define CHG_REG_STATUS 8'h0C
`define CHG_REG_TIMER 8'h10
`define CHG_CTRL1_VSEL_BIT 4
`define CHG_CTRL2_GREEN_BIT 3
`define CHG_CTRL2_RED_BIT 2
`define CHG_CODE_RESET 4'h8
`define CHG_VSEL_RESET 1'b0
`define CHG_EOC_RESET 2'h1
`define CHG_CODE_MAX 4'hD
`define CHG_CODE_100MA 4'h0
`define CHG_MA_BASE 10'd100
`define CHG_MA_STEP 10'd50
`define CHG_CLK_HZ 100000000
`define CHG_TICK_CYCLES 100000000
`define CHG_TIMER_HOURS_X10 56
`define CHG_TIMER_TICKS (`CHG_TIMER_HOURS_X10 * 3600 / 10)
`endif

/* File: logic/charger_pkg.sv */
// types for the charger control block
package charger_pkg;
	typedef enum logic [2:0] {
		ST_OFF,
		ST_PREQUAL,
		ST_CC,
		ST_CV,
		ST_MAINT,
		ST_FAULT,
		ST_LDO
	} chg_state_t;
	typedef enum logic [1:0] {
		TS_LDO,
		TS_OFF,
		TS_ON
	} ts_class_t;
endpackage : charger_pkg

/* File: logic/charger_control_fsm.sv */
// charger control state machine with wishbone register slave
`timescale 1ns/1ps
`include "charger_regs.svh"
module charger_control_fsm #(
	parameter int unsigned TICK_CYCLES = `CHG_TICK_CYCLES,
	parameter int unsigned TIMER_TICKS = `CHG_TIMER_TICKS
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic mode_ac_i,
	input wire logic current_select_pin_i,
	input wire logic enable_i,
	input wire logic supply_ok_i,
	input wire logic ts_ge_2v7_i,
	input wire logic ts_ge_2v427_i,
	input wire logic ts_gt_1v39_i,
	input wire logic batt_gt_3v0_i,
	input wire logic batt_at_reg_i,
	input wire logic ichg_below_eoc_i,
	input wire logic batt_droop_200mv_i,
	output logic charge_en_o,
	output logic ldo_en_o,
	output logic prequal_o,
	output logic [9:0] ichg_ma_o,
	output logic [1:0] eoc_sel_o,
	output logic vreg_4v2_o,
	output logic charging_indicator_o,
	output logic charging_indicator_oe_o,
	output logic eoc_indicator_o,
	output logic eoc_indicator_oe_o
);
	typedef struct packed {
		charger_pkg::chg_state_t st;
		logic [3:0] ac_code;
		logic vsel;
		logic [1:0] eoc;
		logic [3:0] usb_code;
		logic recharge;
		logic fault;
		logic [26:0] pre;
		logic [14:0] tmr;
		logic ack;
		logic [31:0] dat;
		logic [9:0] ma;
		logic red;
		logic green;
	} state_t;

	state_t s_r;
	state_t s_nxt;
	charger_pkg::ts_class_t ts_cls;
	logic [3:0] act_code;
	logic wb_req;
	logic wr;

	// thermistor class from the three comparators
	always_comb begin
		if (ts_ge_2v7_i) begin
			ts_cls = charger_pkg::TS_LDO;
		end else if (ts_ge_2v427_i || !ts_gt_1v39_i) begin
			ts_cls = charger_pkg::TS_OFF;
		end else begin
			ts_cls = charger_pkg::TS_ON;
		end
	end

	// mode pin picks the code; select pin only matters in usb mode
	always_comb begin
		if (mode_ac_i) begin
			act_code = s_r.ac_code;
		end else if (current_select_pin_i) begin
			act_code = `CHG_CODE_100MA;
		end else begin
			act_code = s_r.usb_code;
		end
	end

	assign wb_req = wb_cyc_i && wb_stb_i && !s_r.ack;
	assign wr = wb_req && wb_we_i && wb_sel_i[0];

	always_comb begin
		s_nxt = s_r;
		s_nxt.ack = wb_req;
		s_nxt.dat = 32'h0000_0000;
		// register writes; codes above the top step are clamped
		if (wr) begin
			unique case (wb_adr_i)
				`CHG_REG_CTRL1: begin
					s_nxt.ac_code = (wb_dat_i[3:0] > `CHG_CODE_MAX) ? `CHG_CODE_MAX : wb_dat_i[3:0];
					s_nxt.vsel = wb_dat_i[`CHG_CTRL1_VSEL_BIT];
				end
				`CHG_REG_CTRL2: begin
					// code 0 is not an eoc step; keep old value
					if (wb_dat_i[1:0] != 2'h0) begin
						s_nxt.eoc = wb_dat_i[1:0];
					end
				end
				`CHG_REG_USB: begin
					s_nxt.usb_code = (wb_dat_i[3:0] > `CHG_CODE_MAX) ? `CHG_CODE_MAX : wb_dat_i[3:0];
				end
				default: begin
				end
			endcase
		end
		// reads; unmapped offsets answer zero
		if (wb_req && !wb_we_i) begin
			unique case (wb_adr_i)
				`CHG_REG_CTRL1: s_nxt.dat = {27'h0, s_r.vsel, s_r.ac_code};
				`CHG_REG_CTRL2: s_nxt.dat = {28'h0, s_r.green, s_r.red, s_r.eoc};
				`CHG_REG_USB: s_nxt.dat = {28'h0, s_r.usb_code};
				`CHG_REG_STATUS: s_nxt.dat = {27'h0, s_r.fault, s_r.recharge, 3'(s_r.st)};
				`CHG_REG_TIMER: s_nxt.dat = {17'h0, s_r.tmr};
				default: s_nxt.dat = 32'h0000_0000;
			endcase
		end

		// prescaled slow tick drives the safety timer during cc only
		if (s_r.st == charger_pkg::ST_CC) begin
			if (s_r.pre == 27'(TICK_CYCLES - 1)) begin
				s_nxt.pre = 27'h0;
				s_nxt.tmr = s_r.tmr + 15'h1;
			end else begin
				s_nxt.pre = s_r.pre + 27'h1;
			end
		end

		// losing the supply ends the recharge history, so the next charge from off or ldo shows red again
		if (!supply_ok_i) begin
			s_nxt.recharge = 1'b0;
		end

		// charge sequence
		if (!enable_i) begin
			// shutdown in either mode, timer cleared
			s_nxt.st = charger_pkg::ST_OFF;
			s_nxt.pre = 27'h0;
			s_nxt.tmr = 15'h0;
			s_nxt.recharge = 1'b0;
			s_nxt.fault = 1'b0;
		end else if (ts_cls == charger_pkg::TS_LDO) begin
			s_nxt.st = charger_pkg::ST_LDO;
			s_nxt.pre = 27'h0;
			s_nxt.tmr = 15'h0;
		end else if (ts_cls == charger_pkg::TS_OFF) begin
			// immediate suspend; fault is lit while out of range, unless the excursion starts in off
			s_nxt.st = charger_pkg::ST_OFF;
			s_nxt.pre = 27'h0;
			s_nxt.tmr = 15'h0;
		end else begin
			unique case (s_r.st)
				charger_pkg::ST_OFF, charger_pkg::ST_LDO: begin
					// restart from the top with a fresh timer
					if (supply_ok_i && !s_r.fault) begin
						s_nxt.st = charger_pkg::ST_PREQUAL;
						s_nxt.tmr = 15'h0;
						s_nxt.pre = 27'h0;
					end
				end
				charger_pkg::ST_PREQUAL: begin
					if (batt_gt_3v0_i) begin
						s_nxt.st = charger_pkg::ST_CC;
						s_nxt.tmr = 15'h0;
						s_nxt.pre = 27'h0;
					end
				end
				charger_pkg::ST_CC: begin
					if (s_r.tmr >= 15'(TIMER_TICKS)) begin
						s_nxt.st = charger_pkg::ST_FAULT;
						s_nxt.fault = 1'b1;
					end else if (batt_at_reg_i) begin
						s_nxt.st = charger_pkg::ST_CV;
					end
				end
				charger_pkg::ST_CV: begin
					if (ichg_below_eoc_i) begin
						s_nxt.st = charger_pkg::ST_MAINT;
					end
				end
				charger_pkg::ST_MAINT: begin
					if (batt_droop_200mv_i && supply_ok_i) begin
						s_nxt.st = charger_pkg::ST_PREQUAL;
						s_nxt.recharge = 1'b1;
					end
				end
				charger_pkg::ST_FAULT: begin
					s_nxt.st = charger_pkg::ST_FAULT;
				end
			endcase
		end

		// registered charge current, linear from the active code
		s_nxt.ma = `CHG_MA_BASE + 10'(act_code) * `CHG_MA_STEP;

		// indicator decode
		if (!enable_i) begin
			s_nxt.red = 1'b0;
			s_nxt.green = 1'b1;
		// latched fault stays lit after a temperature excursion; ldo shows nothing
		end else if ((s_nxt.fault && s_nxt.st != charger_pkg::ST_LDO)
				|| (ts_cls == charger_pkg::TS_OFF && s_r.st != charger_pkg::ST_OFF)
				|| (ts_cls == charger_pkg::TS_OFF && s_r.red && s_r.green)) begin
			s_nxt.red = 1'b1;
			s_nxt.green = 1'b1;
		end else if (s_nxt.st == charger_pkg::ST_MAINT || (s_nxt.recharge
				&& s_nxt.st != charger_pkg::ST_OFF && s_nxt.st != charger_pkg::ST_LDO)) begin
			s_nxt.red = 1'b0;
			s_nxt.green = 1'b1;
		end else if (s_nxt.st == charger_pkg::ST_PREQUAL || s_nxt.st == charger_pkg::ST_CC
				|| s_nxt.st == charger_pkg::ST_CV) begin
			s_nxt.red = 1'b1;
			s_nxt.green = 1'b0;
		end else begin
			s_nxt.red = 1'b0;
			s_nxt.green = 1'b0;
		end
	end

	// single state register, synchronous reset to power-up defaults
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_r <= '0;
			s_r.st <= charger_pkg::ST_OFF;
			s_r.ac_code <= `CHG_CODE_RESET;
			s_r.usb_code <= `CHG_CODE_RESET;
			s_r.vsel <= `CHG_VSEL_RESET;
			s_r.eoc <= `CHG_EOC_RESET;
			s_r.ma <= `CHG_MA_BASE;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign wb_ack_o = s_r.ack;
	assign wb_dat_o = s_r.dat;
	assign charge_en_o = (s_r.st == charger_pkg::ST_CC) || (s_r.st == charger_pkg::ST_CV)
		|| (s_r.st == charger_pkg::ST_PREQUAL);
	assign prequal_o = s_r.st == charger_pkg::ST_PREQUAL;
	assign ldo_en_o = s_r.st == charger_pkg::ST_LDO;
	assign ichg_ma_o = s_r.ma;
	assign eoc_sel_o = s_r.eoc;
	assign vreg_4v2_o = s_r.vsel;
	// open drain: pull low when lit, release otherwise
	assign charging_indicator_o = 1'b0;
	assign charging_indicator_oe_o = s_r.red;
	assign eoc_indicator_o = 1'b0;
	assign eoc_indicator_oe_o = s_r.green;

	// checks
	timer_fault_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(s_r.st == charger_pkg::ST_CC && s_r.tmr >= 15'(TIMER_TICKS) && enable_i
		&& ts_cls == charger_pkg::TS_ON) |=> (s_r.st == charger_pkg::ST_FAULT && s_r.fault))
		else $error("timer expiry did not fault");
	usb_limit_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(!mode_ac_i && current_select_pin_i) |=> (ichg_ma_o == `CHG_MA_BASE))
		else $error("usb select high not 100 mA");
	temp_suspend_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(ts_cls == charger_pkg::TS_OFF) |=> !charge_en_o)
		else $error("charging not suspended");
	disable_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!enable_i |=> (!charge_en_o && !ldo_en_o && eoc_indicator_oe_o && !charging_indicator_oe_o))
		else $error("disable not honoured");
	ldo_entry_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(enable_i && ts_ge_2v7_i) |=> ldo_en_o)
		else $error("ldo not entered");
	cc_entry_a: assert property (@(posedge clk_i) disable iff (rst_i)
		($rose(s_r.st == charger_pkg::ST_CC)) |-> (s_r.tmr == 15'h0))
		else $error("timer not cleared at cc entry");
	fault_leds_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(s_r.st == charger_pkg::ST_FAULT && enable_i) |-> (s_r.red && s_r.green))
		else $error("fault leds wrong");
	ac_current_a: assert property (@(posedge clk_i) disable iff (rst_i)
		mode_ac_i ##1 mode_ac_i |-> (ichg_ma_o == `CHG_MA_BASE + 10'($past(s_r.ac_code)) * `CHG_MA_STEP))
		else $error("ac current wrong");
	ldo_leds_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(ldo_en_o && enable_i) |-> (!s_r.red && !s_r.green))
		else $error("ldo leds lit");
	maint_leds_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(s_r.st == charger_pkg::ST_MAINT) |-> (s_r.green && !s_r.red))
		else $error("maintenance leds wrong");
	wb_ack_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
		else $error("bus ack late");
	// latched fault keeps both indicators lit outside ldo until disable
	fault_latch_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(s_r.fault && s_r.st != charger_pkg::ST_LDO) |-> (s_r.red && s_r.green))
		else $error("fault not latched on leds");
	// usb with select low follows the usb code
	usb_low_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(!mode_ac_i && !current_select_pin_i) |=> (ichg_ma_o == `CHG_MA_BASE + 10'($past(s_r.usb_code)) * `CHG_MA_STEP))
		else $error("usb select low current wrong");
	// thermistor band between the upper comparators means charger off
	ts_off_band_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(enable_i && !ts_ge_2v7_i && ts_ge_2v427_i) |=> (!charge_en_o && !ldo_en_o))
		else $error("ts off band not honoured");
	// back in range restarts at prequal with a cleared timer
	temp_restart_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(s_r.st == charger_pkg::ST_OFF && ts_cls == charger_pkg::TS_ON && enable_i
		&& supply_ok_i && !s_r.fault) |=> (prequal_o && s_r.tmr == 15'h0))
		else $error("no restart after temperature recovery");
	prequal_exit_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(s_r.st == charger_pkg::ST_PREQUAL && batt_gt_3v0_i && enable_i
		&& ts_cls == charger_pkg::TS_ON) |=> (s_r.st == charger_pkg::ST_CC))
		else $error("prequal not left");
	// maintenance restarts only while the supply is present
	recharge_start_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(s_r.st == charger_pkg::ST_MAINT && batt_droop_200mv_i && supply_ok_i && enable_i
		&& ts_cls == charger_pkg::TS_ON) |=> (prequal_o && s_r.recharge))
		else $error("recharge not started");
	no_supply_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(s_r.st == charger_pkg::ST_MAINT && !supply_ok_i && enable_i
		&& ts_cls == charger_pkg::TS_ON) |=> !charge_en_o)
		else $error("recharge without supply");
	eoc_range_a: assert property (@(posedge clk_i) disable iff (rst_i)
		eoc_sel_o != 2'h0)
		else $error("eoc code out of range");
	// current never leaves the 100 to 750 mA window
	current_range_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(ichg_ma_o >= `CHG_MA_BASE && ichg_ma_o <= `CHG_MA_BASE + 10'(`CHG_CODE_MAX) * `CHG_MA_STEP))
		else $error("charge current out of range");
	first_charge_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(charge_en_o && !s_r.recharge) |-> (s_r.red && !s_r.green))
		else $error("first charge leds wrong");
	cv_entry_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(s_r.st == charger_pkg::ST_CC && batt_at_reg_i && s_r.tmr < 15'(TIMER_TICKS)
		&& enable_i && ts_cls == charger_pkg::TS_ON) |=> (s_r.st == charger_pkg::ST_CV))
		else $error("cv not entered");
	// disable must leave no stale timer behind for the next cc entry
	timer_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!enable_i |=> (s_r.tmr == 15'h0 && s_r.pre == 27'h0))
		else $error("timer not cleared on disable");
	cc_seen_c: cover property (@(posedge clk_i) disable iff (rst_i) s_r.st == charger_pkg::ST_CC);
	maint_seen_c: cover property (@(posedge clk_i) disable iff (rst_i)
		s_r.st == charger_pkg::ST_MAINT);
	fault_seen_c: cover property (@(posedge clk_i) disable iff (rst_i)
		s_r.st == charger_pkg::ST_FAULT);
	ldo_seen_c: cover property (@(posedge clk_i) disable iff (rst_i) ldo_en_o);
	recharge_seen_c: cover property (@(posedge clk_i) disable iff (rst_i)
		s_r.recharge && charge_en_o);
endmodule : charger_control_fsm

/* File: dv/battery_model.sv */
// behavioural cell and analog flags that answer the charger
`timescale 1ns/1ps
module battery_model (
	input wire logic clk_i,
	input wire logic charge_en_i,
	input wire logic fast_i,
	input wire logic droop_i,
	output logic batt_gt_3v0_o,
	output logic batt_at_reg_o,
	output logic ichg_below_eoc_o,
	output logic batt_droop_200mv_o
);
	int n = 0;
	// cell only rises while current flows; a slow cell never reaches regulation
	always @(posedge clk_i) begin
		n <= charge_en_i ? n + 1 : 0;
	end
	assign batt_gt_3v0_o = n >= 5;
	assign batt_at_reg_o = fast_i && n >= 8;
	assign ichg_below_eoc_o = fast_i && n >= 11;
	assign batt_droop_200mv_o = droop_i;
endmodule : battery_model

/* File: dv/tb_top.sv */
// self-checking bench for the charger control block
`timescale 1ns/1ps
module tb_top;
	logic clk_i = 0, rst_i = 1, cyc = 0, we = 0, fast = 1, droop = 0;
	logic mode_ac_i = 1, current_select_pin_i = 1, enable_i = 1;
	logic [7:0] adr = 8'h00;
	logic [31:0] dat = 32'h0, wb_dat_o;
	logic [2:0] ts = 3'h7;
	logic wb_ack_o, charge_en_o, ldo_en_o, prequal_o, vreg_4v2_o, red, green;
	logic g3, reg_ok, eoc, drp, red_pin, grn_pin, supply = 1;
	logic [9:0] ichg_ma_o;
	logic [1:0] eoc_sel_o;
	logic [31:0] exp_q[$];
	int fails = 0, n_checks = 0, seed = 32'h22E5, k;
	charger_control_fsm #(.TICK_CYCLES(4), .TIMER_TICKS(5)) i_charger_control_fsm (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .mode_ac_i(mode_ac_i), .enable_i(enable_i),
		.current_select_pin_i(current_select_pin_i), .supply_ok_i(supply),
		.ts_ge_2v7_i(ts[2]), .ts_ge_2v427_i(ts[1]), .ts_gt_1v39_i(ts[0]),
		.batt_gt_3v0_i(g3), .batt_at_reg_i(reg_ok), .ichg_below_eoc_i(eoc),
		.batt_droop_200mv_i(drp), .charge_en_o(charge_en_o), .ldo_en_o(ldo_en_o),
		.prequal_o(prequal_o), .ichg_ma_o(ichg_ma_o), .eoc_sel_o(eoc_sel_o),
		.vreg_4v2_o(vreg_4v2_o), .charging_indicator_o(red_pin),
		.charging_indicator_oe_o(red), .eoc_indicator_o(grn_pin), .eoc_indicator_oe_o(green));
	battery_model i_battery_model (.clk_i(clk_i), .charge_en_i(charge_en_o),
		.fast_i(fast), .droop_i(droop), .batt_gt_3v0_o(g3), .batt_at_reg_o(reg_ok),
		.ichg_below_eoc_o(eoc), .batt_droop_200mv_o(drp));
	initial begin
		forever #5 clk_i = ~clk_i;
	end
	task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR %s exp %h seen %h", nm, exp, seen);
		end
	endtask : check
	// classic single cycle; request held until ack is sampled high
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		cyc <= 1;
		we <= w;
		adr <= a;
		dat <= d;
		if (!w) exp_q.push_back(d);
		@(posedge clk_i iff wb_ack_o === 1'b1);
		cyc <= 0;
		we <= 0;
	endtask : wb
	// pins move on a rising edge, outputs are looked at three falling edges later
	task pins(input logic m, input logic s, input logic e, input logic [2:0] t);
		@(posedge clk_i);
		mode_ac_i <= m;
		current_select_pin_i <= s;
		enable_i <= e;
		ts <= t;
		repeat (3) @(negedge clk_i);
	endtask : pins
	task leds(input logic r, input logic g);
		check("red", red, r);
		check("green", green, g);
		check("red pin", red_pin, 0);
		check("green pin", grn_pin, 0);
	endtask : leds
	function automatic logic [9:0] ma(input int c);
		return c > 13 ? 10'd750 : 10'(100 + 50 * c);
	endfunction : ma
	task print_verdict;
		$display("checks %0d fails %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : print_verdict
	// the ack cycle is settled at the falling edge, before the master releases
	always @(negedge clk_i) begin
		if (wb_ack_o === 1'b1 && we === 1'b0) check("rdata", wb_dat_o, exp_q.pop_front());
	end
	initial begin
		repeat (20000) @(posedge clk_i);
		fails++;
		print_verdict;
	end
	initial begin
		repeat (5) @(posedge clk_i);
		rst_i <= 0;
		wb(0, 8'h00, 32'h08);
		wb(0, 8'h04, 32'h01);
		wb(0, 8'h08, 32'h08);
		wb(0, 8'h14, 32'h00);
		pins(1, 1, 1, 3'h7);
		check("ma", ichg_ma_o, 500);
		check("ldo", ldo_en_o, 1);
		leds(0, 0);
		// every code, with the select pin random, which must not matter in ac mode
		for (int i = 0; i < 16; i++) begin
			@(posedge clk_i);
			current_select_pin_i <= 1'($random(seed));
			wb(1, 8'h00, {27'h0, i[0], i[3:0]});
			repeat (3) @(negedge clk_i);
			check("ma", ichg_ma_o, ma(i));
			check("vsel", vreg_4v2_o, i[0]);
		end
		wb(0, 8'h00, 32'h1D);
		for (int i = 3; i >= 0; i--) begin
			wb(1, 8'h04, i);
			repeat (3) @(negedge clk_i);
			check("eoc", eoc_sel_o, i == 0 ? 1 : i);
		end
		pins(0, 1, 1, 3'h7);
		check("ma", ichg_ma_o, 100);
		pins(0, 0, 1, 3'h7);
		check("ma", ichg_ma_o, 500);
		k = 32'($unsigned($random(seed)) % 14);
		wb(1, 8'h08, k);
		repeat (3) @(negedge clk_i);
		check("ma", ichg_ma_o, ma(k));
		pins(1, 1, 1, 3'h3);
		check("off", {charge_en_o, ldo_en_o}, 0);
		pins(1, 1, 1, 3'h1);
		check("pq", {charge_en_o, prequal_o}, 3);
		leds(1, 0);
		for (k = 0; k < 200 && green !== 1'b1; k++) @(negedge clk_i);
		wb(0, 8'h0C, 32'h04);
		leds(0, 1);
		@(posedge clk_i);
		supply <= 0;
		droop <= 1;
		repeat (3) @(negedge clk_i);
		check("nosup", charge_en_o, 0);
		@(posedge clk_i);
		supply <= 1;
		for (k = 0; k < 50 && charge_en_o !== 1'b1; k++) @(negedge clk_i);
		leds(0, 1);
		pins(1, 1, 1, 3'h0);
		check("susp", charge_en_o, 0);
		leds(1, 1);
		@(posedge clk_i);
		droop <= 0;
		fast <= 0;
		supply <= 0;
		repeat (3) @(negedge clk_i);
		@(posedge clk_i);
		supply <= 1;
		pins(1, 1, 1, 3'h1);
		check("pq", prequal_o, 1);
		leds(1, 0);
		for (k = 0; k < 50 && prequal_o === 1'b1; k++) @(negedge clk_i);
		for (k = 0; k < 99 && charge_en_o === 1'b1; k++) @(negedge clk_i);
		check("tmr", k >= 16 && k <= 24, 1);
		leds(1, 1);
		pins(1, 1, 0, 3'h7);
		check("en", {charge_en_o, ldo_en_o}, 0);
		leds(0, 1);
		pins(1, 1, 1, 3'h7);
		check("ldo", ldo_en_o, 1);
		print_verdict;
	end
endmodule : tb_top
